// ---- pkg/pwmos_pkg.sv ----
package pwmos_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register indices on the plain register port
  localparam logic [3:0] OFS_PERIOD = 4'h0;
  localparam logic [3:0] OFS_DUTY_A = 4'h1;
  localparam logic [3:0] OFS_DUTY_B = 4'h2;
  localparam logic [3:0] OFS_DUTY_C = 4'h3;
  localparam logic [3:0] OFS_DEAD = 4'h4;
  localparam logic [3:0] OFS_MIN_PULSE = 4'h5;
  localparam logic [3:0] OFS_ROUTE = 4'h6;
  localparam logic [3:0] OFS_GATE = 4'h7;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;
  localparam logic [3:0] OFS_ROUTE_LIVE = 4'hA;

  // output_route_and_disable layout
  localparam int ROUTE_W = 9;
  localparam int ROUTE_XOVER_A = 8;
  localparam int ROUTE_DIS_A_HI = 4;
  localparam logic [8:0] ROUTE_RST = 9'h000;

  // gate_chop_control layout
  localparam int GATE_W = 10;
  localparam int GATE_DIV_LSB = 0;
  localparam int GATE_DIV_W = 8;
  localparam int GATE_CHOP_HI = 8;
  localparam int GATE_CHOP_LO = 9;
  localparam logic [9:0] GATE_RST = 10'h000;

  // mode register: bit 0 selects double update
  localparam int MODE_DOUBLE = 0;

  // reset values of the timing registers
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] DEAD_RST = 16'h0000;
  localparam logic [15:0] MIN_PULSE_RST = 16'h0000;

  // chop counter: one carrier half spans 2*(divider+1) clocks
  localparam int CHOP_CNT_W = 9;
  localparam logic [8:0] CHOP_CNT_RST = 9'h000;

  // one high/low pair of gate drive signals
  typedef struct packed {
    logic hi;
    logic lo;
  } pwmos_pair_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pwmos_req_t;

endpackage : pwmos_pkg

// ---- hdl/pwmos_shaper.sv ----
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module pwmos_shaper (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire pwmos_pkg::pwmos_req_t i_req,
  output logic [pwmos_pkg::DATA_W-1:0] o_rdata,
  input wire pwmos_pkg::pwmos_pair_t [2:0] i_raw,
  input wire logic i_period_sync_pulse,
  input wire logic i_second_half,
  output pwmos_pkg::pwmos_pair_t [2:0] o_drive
);

  // software-side registers
  logic [15:0] period_r;
  logic [15:0] duty_r [3];
  logic [15:0] dead_r;
  logic [15:0] min_pulse_r;
  logic [pwmos_pkg::ROUTE_W-1:0] route_r;
  logic [pwmos_pkg::GATE_W-1:0] gate_r;
  logic double_r;

  // working copies, loaded on sync rising edge
  logic [15:0] period_live_r;
  logic [15:0] duty_live_r [3];
  logic [15:0] dead_live_r;
  logic [15:0] min_pulse_live_r;
  logic [pwmos_pkg::ROUTE_W-1:0] route_live_r;

  logic sync_d_r;
  logic [pwmos_pkg::CHOP_CNT_W-1:0] chop_cnt_r;
  logic [pwmos_pkg::CHOP_CNT_W-1:0] chop_cnt_nxt;
  logic carrier_r;
  logic [pwmos_pkg::DATA_W-1:0] rdata_nxt;
  pwmos_pkg::pwmos_pair_t [2:0] drive_nxt;
  logic [5:0] deleted;

  // address decode
  wire wr_period = i_req.wr && (i_req.addr == pwmos_pkg::OFS_PERIOD);
  wire wr_dead = i_req.wr && (i_req.addr == pwmos_pkg::OFS_DEAD);
  wire wr_min = i_req.wr && (i_req.addr == pwmos_pkg::OFS_MIN_PULSE);
  wire wr_route = i_req.wr && (i_req.addr == pwmos_pkg::OFS_ROUTE);
  wire wr_gate = i_req.wr && (i_req.addr == pwmos_pkg::OFS_GATE);
  wire wr_mode = i_req.wr && (i_req.addr == pwmos_pkg::OFS_MODE);
  wire [2:0] wr_duty;
  assign wr_duty[0] = i_req.wr && (i_req.addr == pwmos_pkg::OFS_DUTY_A);
  assign wr_duty[1] = i_req.wr && (i_req.addr == pwmos_pkg::OFS_DUTY_B);
  assign wr_duty[2] = i_req.wr && (i_req.addr == pwmos_pkg::OFS_DUTY_C);

  // sync edge and latch qualification
  wire sync_rise = i_period_sync_pulse && !sync_d_r;
  // single update honours only the period-start pulse, double also the mid-period one
  wire latch_en = sync_rise && (double_r || !i_second_half);

  // chop carrier fields
  wire [7:0] chop_div = gate_r[pwmos_pkg::GATE_DIV_LSB +: pwmos_pkg::GATE_DIV_W];
  wire chop_hi_en = gate_r[pwmos_pkg::GATE_CHOP_HI];
  wire chop_lo_en = gate_r[pwmos_pkg::GATE_CHOP_LO];
  // each carrier half lasts 2*(div+1) clocks, a full period 4*(div+1)
  wire [pwmos_pkg::CHOP_CNT_W-1:0] chop_half_last =
    pwmos_pkg::CHOP_CNT_W'({chop_div, 1'b1});
  wire chop_wrap = (chop_cnt_r >= chop_half_last);
  assign chop_cnt_nxt = chop_wrap ? pwmos_pkg::CHOP_CNT_RST
                                  : chop_cnt_r + pwmos_pkg::CHOP_CNT_W'(1);

  // read mux
  always_comb begin
    rdata_nxt = '0;
    if (!i_req.rd) begin
      rdata_nxt = '0;
    end else if (i_req.addr == pwmos_pkg::OFS_PERIOD) begin
      rdata_nxt = period_r;
    end else if (i_req.addr == pwmos_pkg::OFS_DUTY_A) begin
      rdata_nxt = duty_r[0];
    end else if (i_req.addr == pwmos_pkg::OFS_DUTY_B) begin
      rdata_nxt = duty_r[1];
    end else if (i_req.addr == pwmos_pkg::OFS_DUTY_C) begin
      rdata_nxt = duty_r[2];
    end else if (i_req.addr == pwmos_pkg::OFS_DEAD) begin
      rdata_nxt = dead_r;
    end else if (i_req.addr == pwmos_pkg::OFS_MIN_PULSE) begin
      rdata_nxt = min_pulse_r;
    end else if (i_req.addr == pwmos_pkg::OFS_ROUTE) begin
      rdata_nxt = {7'h00, route_r};
    end else if (i_req.addr == pwmos_pkg::OFS_GATE) begin
      rdata_nxt = {6'h00, gate_r};
    end else if (i_req.addr == pwmos_pkg::OFS_MODE) begin
      rdata_nxt = {15'h0000, double_r};
    end else if (i_req.addr == pwmos_pkg::OFS_STATUS) begin
      rdata_nxt = {9'h000, i_second_half, deleted};
    end else if (i_req.addr == pwmos_pkg::OFS_ROUTE_LIVE) begin
      rdata_nxt = {7'h00, route_live_r};
    end else begin
      rdata_nxt = '0;
    end
  end

  // software registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      period_r <= pwmos_pkg::PERIOD_RST;
      dead_r <= pwmos_pkg::DEAD_RST;
      min_pulse_r <= pwmos_pkg::MIN_PULSE_RST;
      route_r <= pwmos_pkg::ROUTE_RST;
      gate_r <= pwmos_pkg::GATE_RST;
      double_r <= 1'b0;
      o_rdata <= '0;
    end else begin
      if (wr_period) period_r <= i_req.wdata;
      if (wr_dead) dead_r <= i_req.wdata;
      if (wr_min) min_pulse_r <= i_req.wdata;
      if (wr_route) route_r <= i_req.wdata[pwmos_pkg::ROUTE_W-1:0];
      // chop settings act at once; software must set them before the PWM runs
      if (wr_gate) gate_r <= i_req.wdata[pwmos_pkg::GATE_W-1:0];
      if (wr_mode) double_r <= i_req.wdata[pwmos_pkg::MODE_DOUBLE];
      o_rdata <= rdata_nxt;
    end
  end

  // working copies: single update keeps one set for the whole period
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_d_r <= 1'b0;
      period_live_r <= pwmos_pkg::PERIOD_RST;
      dead_live_r <= pwmos_pkg::DEAD_RST;
      min_pulse_live_r <= pwmos_pkg::MIN_PULSE_RST;
      route_live_r <= pwmos_pkg::ROUTE_RST;
    end else begin
      sync_d_r <= i_period_sync_pulse;
      if (latch_en) begin
        period_live_r <= period_r;
        dead_live_r <= dead_r;
        min_pulse_live_r <= min_pulse_r;
        route_live_r <= route_r;
      end
    end
  end

  // chop carrier: free-running square wave, equal high and low time
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      chop_cnt_r <= pwmos_pkg::CHOP_CNT_RST;
      carrier_r <= 1'b0;
    end else begin
      chop_cnt_r <= chop_cnt_nxt;
      if (chop_wrap) carrier_r <= !carrier_r;
    end
  end

  // per-phase shaping chain
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      logic [16:0] hi_on;
      logic [16:0] lo_on;
      logic [16:0] lo_sub;
      logic del_hi;
      logic del_lo;
      logic sh_hi;
      logic sh_lo;
      logic rt_hi;
      logic rt_lo;
      logic en_hi;
      logic en_lo;

      // duty: one set in single update, a fresh set each half in double update
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          duty_r[p] <= pwmos_pkg::DUTY_RST;
          duty_live_r[p] <= pwmos_pkg::DUTY_RST;
        end else begin
          if (wr_duty[p]) duty_r[p] <= i_req.wdata;
          if (latch_en) duty_live_r[p] <= duty_r[p];
        end
      end

      // dead-time adjusted half-period on-times, floored at zero
      assign hi_on = (duty_live_r[p] > dead_live_r) ?
                     17'(duty_live_r[p]) - 17'(dead_live_r) : 17'h00000;
      assign lo_sub = 17'(duty_live_r[p]) + 17'(dead_live_r);
      assign lo_on = (17'(period_live_r) > lo_sub) ?
                     17'(period_live_r) - lo_sub : 17'h00000;
      assign del_hi = hi_on < 17'(min_pulse_live_r);
      assign del_lo = lo_on < 17'(min_pulse_live_r);

      // a deleted side is off for the half, its partner fully on; both short means both off
      assign sh_hi = del_hi ? 1'b0 : (del_lo ? 1'b1 : i_raw[2-p].hi);
      assign sh_lo = del_lo ? 1'b0 : (del_hi ? 1'b1 : i_raw[2-p].lo);
      assign deleted[4-2*p] = del_hi;
      assign deleted[5-2*p] = del_lo;

      // crossover swaps the pair, phase A on the top bit
      wire xo = route_live_r[pwmos_pkg::ROUTE_XOVER_A-p];
      assign rt_hi = xo ? sh_lo : sh_hi;
      assign rt_lo = xo ? sh_hi : sh_lo;

      // disable bits: phase A hi/lo at 4/5, B at 2/3, C at 0/1
      assign en_hi = rt_hi && !route_live_r[pwmos_pkg::ROUTE_DIS_A_HI-2*p];
      assign en_lo = rt_lo && !route_live_r[pwmos_pkg::ROUTE_DIS_A_HI+1-2*p];

      // chopping only touches the active portion, so an off output stays off
      assign drive_nxt[2-p].hi = en_hi && (!chop_hi_en || carrier_r);
      assign drive_nxt[2-p].lo = en_lo && (!chop_lo_en || carrier_r);
    end
  endgenerate

  // one register stage before the pins keeps the drivers glitch free
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_drive <= '0;
    end else begin
      o_drive <= drive_nxt;
    end
  end

endmodule : pwmos_shaper

// ---- sim/pwmos_gate_drv.sv ----
`timescale 1ns/100ps
// gate driver side: counts the clocks each gate is commanded on, no phase view needed
module pwmos_gate_drv (
  input wire logic i_mclk,
  input wire logic i_clr,
  input wire pwmos_pkg::pwmos_pair_t [2:0] i_drive,
  output logic [5:0][15:0] o_on
);
  wire logic [5:0] gate_on = i_drive;
  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < 6; k++) begin
      o_on[k] <= i_clr ? 16'h0000 : o_on[k] + {15'h0000, gate_on[k]};
    end
  end
endmodule : pwmos_gate_drv

// ---- sim/pwmos_shaper_asserts.sv ----
`timescale 1ns/100ps
module pwmos_shaper_asserts (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire pwmos_pkg::pwmos_req_t i_req,
  input wire logic [pwmos_pkg::DATA_W-1:0] o_rdata,
  input wire pwmos_pkg::pwmos_pair_t [2:0] i_raw,
  input wire logic i_period_sync_pulse,
  input wire logic i_second_half,
  input wire pwmos_pkg::pwmos_pair_t [2:0] o_drive
);
  logic [8:0] route_r;
  logic [8:0] live_r;
  logic [9:0] gate_r;
  logic [9:0] run_r;
  logic mode_r;
  logic sync_r;
  logic gate_wr_d;
  wire logic [5:0] drv = o_drive;
  wire logic wr_gate = i_req.wr && i_req.addr == pwmos_pkg::OFS_GATE;
  wire logic take = i_period_sync_pulse && !sync_r && (mode_r || !i_second_half);
  // disable bits are ordered lo,hi per phase; the output pairs are hi,lo
  wire logic [5:0] dmask = {live_r[4], live_r[5], live_r[2], live_r[3], live_r[0], live_r[1]};
  wire logic [9:0] chop_max = {1'b0, gate_r[7:0], 1'b0} + 10'h002;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      route_r <= 9'h000;
      live_r <= 9'h000;
      gate_r <= 10'h000;
      run_r <= 10'h000;
      mode_r <= 1'b0;
      sync_r <= 1'b0;
      gate_wr_d <= 1'b0;
    end else begin
      sync_r <= i_period_sync_pulse;
      if (i_req.wr && i_req.addr == pwmos_pkg::OFS_ROUTE) route_r <= i_req.wdata[8:0];
      if (wr_gate) gate_r <= i_req.wdata[9:0];
      if (i_req.wr && i_req.addr == pwmos_pkg::OFS_MODE) mode_r <= i_req.wdata[0];
      if (take) live_r <= route_r;
      gate_wr_d <= wr_gate;
      // the first sample after a gate write still shows the output under the previous gate setting
      run_r <= (wr_gate || gate_wr_d) ? 10'h000 : (drv[5] ? run_r + 10'h001 : 10'h000);
    end
  end
  rst_clear_a: assert property ($rose(i_nrst) |-> drv == 6'h00 && o_rdata == 16'h0000)
    else $error("outputs not clear after reset");
  rd_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  unmap_rd_a: assert property (i_req.rd && i_req.addr > pwmos_pkg::OFS_ROUTE_LIVE |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  route_rd_a: assert property (i_req.rd && i_req.addr == pwmos_pkg::OFS_ROUTE |=> o_rdata == {7'h00, $past(route_r)})
    else $error("route register readback wrong");
  gate_rd_a: assert property (i_req.rd && i_req.addr == pwmos_pkg::OFS_GATE |=> o_rdata == {6'h00, $past(gate_r)})
    else $error("gate register readback wrong");
  live_rd_a: assert property (i_req.rd && i_req.addr == pwmos_pkg::OFS_ROUTE_LIVE |=> o_rdata == {7'h00, $past(live_r)})
    else $error("working route copy wrong");
  dis_off_a: assert property ($stable(live_r) |-> (drv & dmask) == 6'h00)
    else $error("disabled output driven");
  chop_run_a: assert property (gate_r[8] |-> run_r <= chop_max)
    else $error("chopped high run too long");
endmodule : pwmos_shaper_asserts
bind pwmos_shaper pwmos_shaper_asserts chk_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(i_req),
  .o_rdata(o_rdata), .i_raw(i_raw), .i_period_sync_pulse(i_period_sync_pulse),
  .i_second_half(i_second_half), .o_drive(o_drive));

// ---- sim/pwmos_shaper_tb.sv ----
`timescale 1ns/100ps
module pwmos_shaper_tb;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  pwmos_pkg::pwmos_req_t req = '0;
  logic [15:0] rdata;
  pwmos_pkg::pwmos_pair_t [2:0] raw = '0;
  pwmos_pkg::pwmos_pair_t [2:0] drive;
  logic sync = 1'b0;
  logic half = 1'b0;
  logic clr = 1'b0;
  logic [5:0][15:0] on;
  int failures = 0;
  int checks = 0;
  always #25 i_mclk = ~i_mclk;
  pwmos_shaper dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(req), .o_rdata(rdata),
    .i_raw(raw), .i_period_sync_pulse(sync), .i_second_half(half), .o_drive(drive));
  pwmos_gate_drv drv_u (.i_mclk(i_mclk), .i_clr(clr), .i_drive(drive), .o_on(on));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string w);
    @(posedge i_mclk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, e, w);
  endtask : rd
  task automatic pulse(input logic h);
    @(posedge i_mclk);
    sync <= 1'b1;
    half <= h;
    @(posedge i_mclk);
    sync <= 1'b0;
    @(posedge i_mclk);
  endtask : pulse
  task automatic dchk(input logic [5:0] e, input string w);
    repeat (2) @(posedge i_mclk);
    #1;
    chk({10'h000, drive}, {10'h000, e}, w);
  endtask : dchk
  task automatic t_reset;
    rd(pwmos_pkg::OFS_ROUTE, 16'h0000, "route reset");
    rd(pwmos_pkg::OFS_GATE, 16'h0000, "gate reset");
    rd(4'hF, 16'h0000, "unmapped");
    wr(pwmos_pkg::OFS_ROUTE, 16'hFFFF);
    rd(pwmos_pkg::OFS_ROUTE, 16'h01FF, "route width");
    $display("test reset done");
  endtask : t_reset
  task automatic t_sync;
    wr(pwmos_pkg::OFS_ROUTE, 16'h0100);
    rd(pwmos_pkg::OFS_ROUTE_LIVE, 16'h0000, "live before sync");
    pulse(1'b1);
    rd(pwmos_pkg::OFS_ROUTE_LIVE, 16'h0000, "live mid single");
    pulse(1'b0);
    rd(pwmos_pkg::OFS_ROUTE_LIVE, 16'h0100, "live single");
    wr(pwmos_pkg::OFS_MODE, 16'h0001);
    wr(pwmos_pkg::OFS_ROUTE, 16'h0080);
    pulse(1'b1);
    rd(pwmos_pkg::OFS_ROUTE_LIVE, 16'h0080, "live double");
    wr(pwmos_pkg::OFS_MODE, 16'h0000);
    $display("test sync done");
  endtask : t_sync
  task automatic t_cross;
    int p;
    @(posedge i_mclk);
    raw <= 6'h2A;
    for (p = 0; p < 3; p++) begin
      wr(pwmos_pkg::OFS_ROUTE, 16'h0100 >> p);
      pulse(1'b0);
      dchk(6'h2A ^ (6'h30 >> (2 * p)), "crossover");
    end
    $display("test crossover done");
  endtask : t_cross
  task automatic t_dis;
    wr(pwmos_pkg::OFS_ROUTE, 16'h00A7);
    pulse(1'b0);
    dchk(6'h24, "disable after crossover");
    $display("test disable done");
  endtask : t_dis
  task automatic t_min;
    wr(pwmos_pkg::OFS_ROUTE, 16'h0000);
    wr(pwmos_pkg::OFS_PERIOD, 16'h00C8);
    wr(pwmos_pkg::OFS_DUTY_A, 16'h0005);
    wr(pwmos_pkg::OFS_DEAD, 16'h0003);
    wr(pwmos_pkg::OFS_MIN_PULSE, 16'h000A);
    pulse(1'b0);
    dchk(6'h15, "short pulse deleted");
    rd(pwmos_pkg::OFS_STATUS, 16'h0015, "deleted flags all high sides");
    wr(pwmos_pkg::OFS_MIN_PULSE, 16'h0002);
    pulse(1'b0);
    dchk(6'h25, "pulse at minimum kept");
    rd(pwmos_pkg::OFS_STATUS, 16'h0005, "deleted flags b and c");
    wr(pwmos_pkg::OFS_MIN_PULSE, 16'h0000);
    pulse(1'b0);
    dchk(6'h2A, "no deletion");
    $display("test min pulse done");
  endtask : t_min
  task automatic t_chop;
    int s;
    @(posedge i_mclk);
    raw <= 6'h3E;
    for (s = 0; s < 2; s++) begin
      wr(pwmos_pkg::OFS_GATE, s ? 16'h0203 : 16'h0103);
      // let the carrier take the new divider before counting
      repeat (20) @(posedge i_mclk);
      clr <= 1'b1;
      @(posedge i_mclk);
      clr <= 1'b0;
      repeat (64) @(posedge i_mclk);
      #1;
      chk(on[5], s ? 16'h0040 : 16'h0020, "chop high side");
      chk(on[4], s ? 16'h0020 : 16'h0040, "chop low side");
      chk(on[0], 16'h0000, "chopped idle output stays off");
    end
    wr(pwmos_pkg::OFS_GATE, 16'h0000);
    $display("test chop done");
  endtask : t_chop
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_reset;
    t_sync;
    t_cross;
    t_dis;
    t_min;
    t_chop;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    print_verdict;
  end
endmodule : pwmos_shaper_tb
